// ### pkg/iorsd_pkg.sv
// io register space decode: package of offsets, field layouts, reset values and carriers
// assumes the core presents one access per cycle on the request struct below
package iorsd_pkg;

  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam logic [5:0] IORSD_BIT_SPACE_TOP = 6'h1f;
  localparam logic [5:0] IORSD_PORT_SPACE_TOP = 6'h3f;
  localparam logic [7:0] IORSD_DATA_IO_BASE = 8'h20;
  localparam logic [7:0] IORSD_EXT_BASE = 8'h60;
  localparam logic [7:0] IORSD_EXT_TOP = 8'hff;
  localparam int IORSD_EXT_DEPTH = 160;

  localparam logic [5:0] IORSD_PORT_B_PIN_LEVEL = 6'h03;
  localparam logic [5:0] IORSD_PORT_C_PIN_LEVEL = 6'h06;
  localparam logic [5:0] IORSD_PORT_D_PIN_LEVEL = 6'h09;
  localparam logic [5:0] IORSD_PORT_E_PIN_LEVEL = 6'h0c;
  localparam logic [5:0] IORSD_DIR_B = 6'h04;
  localparam logic [5:0] IORSD_OUT_B = 6'h05;
  localparam logic [5:0] IORSD_DIR_C = 6'h07;
  localparam logic [5:0] IORSD_OUT_C = 6'h08;
  localparam logic [5:0] IORSD_DIR_D = 6'h0a;
  localparam logic [5:0] IORSD_OUT_D = 6'h0b;
  localparam logic [5:0] IORSD_DIR_E = 6'h0d;
  localparam logic [5:0] IORSD_OUT_E = 6'h0e;
  localparam logic [5:0] IORSD_T8_FLAGS = 6'h15;
  localparam logic [5:0] IORSD_T16_FLAGS = 6'h16;
  localparam logic [5:0] IORSD_GP1 = 6'h19;
  localparam logic [5:0] IORSD_GP2 = 6'h1a;
  localparam logic [5:0] IORSD_GP3 = 6'h1b;
  localparam logic [5:0] IORSD_XIRQ_FLAGS = 6'h1c;
  localparam logic [5:0] IORSD_XIRQ_MASK = 6'h1d;
  localparam logic [5:0] IORSD_GP0 = 6'h1e;
  localparam logic [5:0] IORSD_NVM_CTRL = 6'h1f;
  localparam logic [5:0] IORSD_NVM_DATA = 6'h20;
  localparam logic [5:0] IORSD_NVM_ADDR_LO = 6'h21;
  localparam logic [5:0] IORSD_NVM_ADDR_HI = 6'h22;
  localparam logic [5:0] IORSD_PRESC_SYNC = 6'h23;
  localparam logic [5:0] IORSD_T8_CTRL_A = 6'h24;
  localparam logic [5:0] IORSD_T8_CTRL_B = 6'h25;
  localparam logic [5:0] IORSD_T8_COUNT = 6'h26;
  localparam logic [5:0] IORSD_T8_CMP_A = 6'h27;
  localparam logic [5:0] IORSD_T8_CMP_B = 6'h28;

  // ----------------------------------------------------------------
  // implemented-bit masks (reserved bits are zero)
  // ----------------------------------------------------------------
  localparam logic [7:0] IORSD_MASK_FULL = 8'hff;
  localparam logic [7:0] IORSD_MASK_PORT_E = 8'h07;
  localparam logic [7:0] IORSD_MASK_T8_FLAGS = 8'h07;
  localparam logic [7:0] IORSD_MASK_T16_FLAGS = 8'h27;
  localparam logic [7:0] IORSD_MASK_XIRQ = 8'h0f;
  localparam logic [7:0] IORSD_MASK_NVM_CTRL = 8'h0f;
  localparam logic [7:0] IORSD_MASK_NVM_ADDR_HI = 8'h0f;
  localparam logic [7:0] IORSD_MASK_PRESC_SYNC = 8'hc1;
  localparam logic [7:0] IORSD_MASK_T8_CTRL_A = 8'hf3;
  localparam logic [7:0] IORSD_MASK_T8_CTRL_B = 8'hcf;
  localparam logic [7:0] IORSD_RESET_VALUE = 8'h00;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IORSD_OP_NONE = 3'h0,
    IORSD_OP_PORT_READ = 3'h1,
    IORSD_OP_PORT_WRITE = 3'h2,
    IORSD_OP_SET_BIT = 3'h3,
    IORSD_OP_CLEAR_BIT = 3'h4,
    IORSD_OP_TEST_BIT = 3'h5,
    IORSD_OP_MEM_READ = 3'h6,
    IORSD_OP_MEM_WRITE = 3'h7
  } iorsd_op_t;

  typedef struct packed {
    iorsd_op_t op;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } iorsd_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
    logic bit_value;
    logic refused;
  } iorsd_rsp_t;

  typedef struct packed {
    logic [7:0] t8;
    logic [7:0] t16;
    logic [7:0] xirq;
  } iorsd_flags_t;

endpackage

// ### hdl/iorsd_sync2.sv
// io register space decode: two-flop synchroniser for a bus of pin levels
// assumes the pins are asynchronous to core_clk
`timescale 1ns/10ps
module iorsd_sync2 import iorsd_pkg::*; #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // level in and out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ### hdl/iorsd_top.sv
// io register space decode: port, bit and data-space access to the low io registers
// assumes the core issues at most one request per cycle and peripherals raise flag pulses
`timescale 1ns/10ps
module iorsd_top import iorsd_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // core access
  input wire iorsd_req_t req,
  output iorsd_rsp_t rsp,
  // pin levels from the ports
  input wire logic [7:0] pin_b,
  input wire logic [7:0] pin_c,
  input wire logic [7:0] pin_d,
  input wire logic [7:0] pin_e,
  // flag set pulses from peripherals
  input wire iorsd_flags_t flag_set,
  // register contents towards peripherals
  output logic [7:0] dir_b,
  output logic [7:0] out_b,
  output logic [7:0] dir_c,
  output logic [7:0] out_c,
  output logic [7:0] dir_d,
  output logic [7:0] out_d,
  output logic [7:0] dir_e,
  output logic [7:0] out_e,
  output iorsd_flags_t flags,
  output logic [7:0] xirq_mask,
  output logic [7:0] nvm_ctrl,
  output logic [7:0] nvm_data,
  output logic [15:0] nvm_addr,
  output logic [7:0] presc_sync,
  output logic [7:0] t8_ctrl_a,
  output logic [7:0] t8_ctrl_b,
  output logic [7:0] t8_count,
  output logic [7:0] t8_cmp_a,
  output logic [7:0] t8_cmp_b
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [31:0] pins_sync;

  iorsd_sync2 #(.WIDTH(32)) u_pin_sync (
    .core_clk(core_clk),
    .reset(reset),
    .async_in({pin_e, pin_d, pin_c, pin_b}),
    .sync_out(pins_sync)
  );

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire is_port_op = (req.op == IORSD_OP_PORT_READ) || (req.op == IORSD_OP_PORT_WRITE);
  wire is_bit_op = (req.op == IORSD_OP_SET_BIT) || (req.op == IORSD_OP_CLEAR_BIT)
    || (req.op == IORSD_OP_TEST_BIT);
  wire is_mem_op = (req.op == IORSD_OP_MEM_READ) || (req.op == IORSD_OP_MEM_WRITE);
  wire is_write = (req.op == IORSD_OP_PORT_WRITE) || (req.op == IORSD_OP_MEM_WRITE);
  // port ops encode only six address bits; upper bits must be zero
  wire port_in_range = (req.addr[7:6] == 2'b00);
  // bit ops reach only the lower half of the port space
  wire bit_in_range = (req.addr <= {2'b00, IORSD_BIT_SPACE_TOP});
  wire mem_io_hit = (req.addr >= IORSD_DATA_IO_BASE) && (req.addr < IORSD_EXT_BASE);
  wire mem_ext_hit = (req.addr >= IORSD_EXT_BASE);
  wire [7:0] mem_io_off = req.addr - IORSD_DATA_IO_BASE;

  wire io_access = (is_port_op && port_in_range) || (is_bit_op && bit_in_range)
    || (is_mem_op && mem_io_hit);
  wire ext_access = is_mem_op && mem_ext_hit;
  wire [5:0] io_addr = is_mem_op ? mem_io_off[5:0] : req.addr[5:0];
  wire refused = (req.op != IORSD_OP_NONE) && !io_access && !ext_access;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] regs_q [0:63];
  logic [7:0] ext_q [0:IORSD_EXT_DEPTH-1];
  logic [7:0] cur_val;
  logic [7:0] impl_mask;
  logic is_w1c;
  logic is_ro;

  always_comb begin
    impl_mask = IORSD_MASK_FULL;
    is_w1c = 1'b0;
    is_ro = 1'b0;
    cur_val = regs_q[io_addr];
    case (io_addr)
      IORSD_PORT_B_PIN_LEVEL: begin
        cur_val = pins_sync[7:0];
        is_ro = 1'b1;
      end
      IORSD_PORT_C_PIN_LEVEL: begin
        cur_val = pins_sync[15:8];
        is_ro = 1'b1;
      end
      IORSD_PORT_D_PIN_LEVEL: begin
        cur_val = pins_sync[23:16];
        is_ro = 1'b1;
      end
      IORSD_PORT_E_PIN_LEVEL: begin
        cur_val = pins_sync[31:24] & IORSD_MASK_PORT_E;
        impl_mask = IORSD_MASK_PORT_E;
        is_ro = 1'b1;
      end
      IORSD_DIR_B, IORSD_OUT_B, IORSD_DIR_C, IORSD_OUT_C, IORSD_DIR_D, IORSD_OUT_D,
      IORSD_GP0, IORSD_GP1, IORSD_GP2, IORSD_GP3, IORSD_NVM_DATA, IORSD_NVM_ADDR_LO,
      IORSD_T8_COUNT, IORSD_T8_CMP_A, IORSD_T8_CMP_B: impl_mask = IORSD_MASK_FULL;
      IORSD_DIR_E, IORSD_OUT_E: impl_mask = IORSD_MASK_PORT_E;
      IORSD_T8_FLAGS: begin
        impl_mask = IORSD_MASK_T8_FLAGS;
        is_w1c = 1'b1;
      end
      IORSD_T16_FLAGS: begin
        impl_mask = IORSD_MASK_T16_FLAGS;
        is_w1c = 1'b1;
      end
      IORSD_XIRQ_FLAGS: begin
        impl_mask = IORSD_MASK_XIRQ;
        is_w1c = 1'b1;
      end
      IORSD_XIRQ_MASK: impl_mask = IORSD_MASK_XIRQ;
      IORSD_NVM_CTRL: impl_mask = IORSD_MASK_NVM_CTRL;
      IORSD_NVM_ADDR_HI: impl_mask = IORSD_MASK_NVM_ADDR_HI;
      IORSD_PRESC_SYNC: impl_mask = IORSD_MASK_PRESC_SYNC;
      IORSD_T8_CTRL_A: impl_mask = IORSD_MASK_T8_CTRL_A;
      IORSD_T8_CTRL_B: impl_mask = IORSD_MASK_T8_CTRL_B;
      default: begin
        impl_mask = IORSD_RESET_VALUE;
        cur_val = IORSD_RESET_VALUE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // write data formation
  // ----------------------------------------------------------------
  wire [7:0] bit_onehot = 8'h01 << req.bit_sel;
  wire set_op = io_access && (req.op == IORSD_OP_SET_BIT);
  wire clr_op = io_access && (req.op == IORSD_OP_CLEAR_BIT);
  wire full_wr = io_access && is_write;
  logic [7:0] new_val;
  logic [7:0] clear_bits;

  always_comb begin
    new_val = regs_q[io_addr];
    clear_bits = 8'h00;
    if (is_w1c) begin
      // a set-bit op clears only the addressed bit, so sibling flags survive; a full write clears every bit written as one
      if (set_op) begin
        clear_bits = bit_onehot & impl_mask;
      end else if (full_wr) begin
        clear_bits = req.wdata & impl_mask;
      end
    end else if (set_op) begin
      new_val = regs_q[io_addr] | (bit_onehot & impl_mask);
    end else if (clr_op) begin
      new_val = regs_q[io_addr] & ~bit_onehot;
    end else if (full_wr) begin
      new_val = req.wdata & impl_mask;
    end
  end

  wire do_plain_wr = (set_op || clr_op || full_wr) && !is_w1c && !is_ro
    && (impl_mask != 8'h00);
  wire [7:0] ext_idx = req.addr - IORSD_EXT_BASE;

  // ----------------------------------------------------------------
  // flag next values
  // ----------------------------------------------------------------
  // a flag event in the clearing cycle wins over the clear
  wire [7:0] t8_clr = (io_addr == IORSD_T8_FLAGS) ? clear_bits : 8'h00;
  wire [7:0] t16_clr = (io_addr == IORSD_T16_FLAGS) ? clear_bits : 8'h00;
  wire [7:0] xirq_clr = (io_addr == IORSD_XIRQ_FLAGS) ? clear_bits : 8'h00;
  wire [7:0] t8_flags_d = (flag_set.t8 & IORSD_MASK_T8_FLAGS)
    | (regs_q[IORSD_T8_FLAGS] & ~t8_clr);
  wire [7:0] t16_flags_d = (flag_set.t16 & IORSD_MASK_T16_FLAGS)
    | (regs_q[IORSD_T16_FLAGS] & ~t16_clr);
  wire [7:0] xirq_flags_d = (flag_set.xirq & IORSD_MASK_XIRQ)
    | (regs_q[IORSD_XIRQ_FLAGS] & ~xirq_clr);

  // ----------------------------------------------------------------
  // storage update
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 64; i++) begin
        regs_q[i] <= IORSD_RESET_VALUE;
      end
    end else begin
      if (do_plain_wr) begin
        regs_q[io_addr] <= new_val;
      end
      regs_q[IORSD_T8_FLAGS] <= t8_flags_d;
      regs_q[IORSD_T16_FLAGS] <= t16_flags_d;
      regs_q[IORSD_XIRQ_FLAGS] <= xirq_flags_d;
    end
  end

  // extended space is a plain array; no reset so it maps to memory
  always_ff @(posedge core_clk) begin
    if (ext_access && (req.op == IORSD_OP_MEM_WRITE)) begin
      ext_q[ext_idx] <= req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // answer
  // ----------------------------------------------------------------
  wire rd_op = (req.op == IORSD_OP_PORT_READ) || (req.op == IORSD_OP_MEM_READ)
    || (req.op == IORSD_OP_TEST_BIT);
  wire [7:0] rd_val = ext_access ? ext_q[ext_idx] : (io_access ? cur_val : 8'h00);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rsp <= '0;
    end else begin
      rsp.valid <= (req.op != IORSD_OP_NONE);
      rsp.rdata <= rd_op ? rd_val : 8'h00;
      rsp.bit_value <= (req.op == IORSD_OP_TEST_BIT) && io_access
        && cur_val[req.bit_sel];
      rsp.refused <= refused;
    end
  end

  // ----------------------------------------------------------------
  // outputs from flops
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      {dir_b, out_b, dir_c, out_c, dir_d, out_d, dir_e, out_e} <= '0;
      flags <= '0;
      {xirq_mask, nvm_ctrl, nvm_data, presc_sync} <= '0;
      nvm_addr <= '0;
      {t8_ctrl_a, t8_ctrl_b, t8_count, t8_cmp_a, t8_cmp_b} <= '0;
    end else begin
      {dir_b, out_b} <= {regs_q[IORSD_DIR_B], regs_q[IORSD_OUT_B]};
      {dir_c, out_c} <= {regs_q[IORSD_DIR_C], regs_q[IORSD_OUT_C]};
      {dir_d, out_d} <= {regs_q[IORSD_DIR_D], regs_q[IORSD_OUT_D]};
      {dir_e, out_e} <= {regs_q[IORSD_DIR_E], regs_q[IORSD_OUT_E]};
      flags <= {regs_q[IORSD_T8_FLAGS], regs_q[IORSD_T16_FLAGS], regs_q[IORSD_XIRQ_FLAGS]};
      xirq_mask <= regs_q[IORSD_XIRQ_MASK];
      nvm_ctrl <= regs_q[IORSD_NVM_CTRL];
      nvm_data <= regs_q[IORSD_NVM_DATA];
      nvm_addr <= {regs_q[IORSD_NVM_ADDR_HI], regs_q[IORSD_NVM_ADDR_LO]};
      presc_sync <= regs_q[IORSD_PRESC_SYNC];
      t8_ctrl_a <= regs_q[IORSD_T8_CTRL_A];
      t8_ctrl_b <= regs_q[IORSD_T8_CTRL_B];
      t8_count <= regs_q[IORSD_T8_COUNT];
      t8_cmp_a <= regs_q[IORSD_T8_CMP_A];
      t8_cmp_b <= regs_q[IORSD_T8_CMP_B];
    end
  end

endmodule

// ### testbench/iorsd_checker.sv
// io register space decode: assertions on the core access ports, the flags and out_b of the top
// assumes one request held for one cycle and a registered one-cycle answer
`timescale 1ns/10ps
module iorsd_checker import iorsd_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // access and observed state
  input wire iorsd_req_t req,
  input wire iorsd_rsp_t rsp,
  input wire iorsd_flags_t flag_set,
  input wire iorsd_flags_t flags,
  input wire logic [7:0] out_b
);
  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  wire logic bit_op = req.op inside {IORSD_OP_SET_BIT, IORSD_OP_CLEAR_BIT, IORSD_OP_TEST_BIT};
  wire logic port_op = req.op inside {IORSD_OP_PORT_READ, IORSD_OP_PORT_WRITE};
  wire logic mem_op = req.op inside {IORSD_OP_MEM_READ, IORSD_OP_MEM_WRITE};

  AST_ANSWER: assert property (req.op != IORSD_OP_NONE |=> rsp.valid)
    else $error("no answer one cycle after a request");
  AST_IDLE: assert property (req.op == IORSD_OP_NONE |=> !rsp.valid)
    else $error("answer without a request");
  AST_BIT_RANGE: assert property (bit_op |=> rsp.refused == $past(req.addr > 8'h1f))
    else $error("bit op range decode wrong");
  AST_PORT_RANGE: assert property (port_op |=> rsp.refused == $past(req.addr > 8'h3f))
    else $error("port op range decode wrong");
  AST_MEM_RANGE: assert property (mem_op |=> rsp.refused == $past(req.addr < 8'h20))
    else $error("data-space op range decode wrong");
  AST_REFUSED_ZERO: assert property (rsp.refused |-> rsp.rdata == 8'h00)
    else $error("refused access returned data");
  AST_W1C: assert property (req.op == IORSD_OP_PORT_WRITE && req.addr == 8'h15 &&
    flag_set.t8 == 8'h00 |-> ##2 (flags.t8 & $past(req.wdata, 2)) == 8'h00)
    else $error("flag not cleared by writing one");
  AST_TEST_BIT: assert property (req.op == IORSD_OP_TEST_BIT && req.addr == 8'h05
    |=> rsp.bit_value == out_b[$past(req.bit_sel)])
    else $error("tested bit differs from register");
endmodule

bind iorsd_top iorsd_checker chk_u (.core_clk(core_clk), .reset(reset), .req(req),
  .rsp(rsp), .flag_set(flag_set), .flags(flags), .out_b(out_b));

// ### testbench/iorsd_core_model.sv
// io register space decode: model of the core issuing one access at a time
// assumes the bench calls access and the answer comes one cycle after the take
`timescale 1ns/10ps
module iorsd_core_model import iorsd_pkg::*; (
  // clock
  input wire logic core_clk,
  // access
  output iorsd_req_t req,
  input wire iorsd_rsp_t rsp
);
  initial req = '0;
  // io addresses with no register behind them
  function automatic logic rsvd(input logic [7:0] x);
    return x inside {[8'h00:8'h02], [8'h0f:8'h14], 8'h17, 8'h18, [8'h29:8'h3f]};
  endfunction
  task automatic access(input iorsd_op_t op, input logic [7:0] a, input logic [2:0] b,
      input logic [7:0] w, output iorsd_rsp_t r);
    r = '0;
    // a write to a reserved io address is never issued
    if ((op == IORSD_OP_PORT_WRITE && rsvd(a)) ||
        (op == IORSD_OP_MEM_WRITE && a < 8'h60 && rsvd(a - 8'h20))) begin
      return;
    end
    @(posedge core_clk);
    #1;
    req <= '{op, a, b, w};
    @(posedge core_clk);
    #1;
    req <= '0;
    r = rsp;
  endtask
endmodule

// ### testbench/io_register_space_decode_bench.sv
// io register space decode: self-checking bench driving core accesses
// assumes the core model holds each request one cycle; ports c and d stay low
`timescale 1ns/10ps
module io_register_space_decode_bench import iorsd_pkg::*;;
  logic core_clk;
  logic reset;
  logic [7:0] pin_b;
  logic [7:0] pin_e;
  iorsd_flags_t flag_set;
  iorsd_req_t req;
  iorsd_rsp_t rsp;
  iorsd_rsp_t r;
  int num_errors = 0;
  int compares = 0;

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  iorsd_core_model core_u (.core_clk(core_clk), .req(req), .rsp(rsp));
  iorsd_top dut_u (.core_clk(core_clk), .reset(reset), .req(req), .rsp(rsp),
    .pin_b(pin_b), .pin_c(8'h00), .pin_d(8'h00), .pin_e(pin_e), .flag_set(flag_set),
    .dir_b(), .out_b(), .dir_c(), .out_c(), .dir_d(), .out_d(), .dir_e(), .out_e(),
    .flags(), .xirq_mask(), .nvm_ctrl(), .nvm_data(), .nvm_addr(), .presc_sync(),
    .t8_ctrl_a(), .t8_ctrl_b(), .t8_count(), .t8_cmp_a(), .t8_cmp_b());

  // ----------------------------------------------------------------
  // compare and access tasks
  // ----------------------------------------------------------------
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic xs(input iorsd_op_t op, input logic [7:0] a, input logic [2:0] b,
      input logic [7:0] w);
    core_u.access(op, a, b, w, r);
    chk1(r.valid, 1'b1);
  endtask
  task automatic rd(input iorsd_op_t op, input logic [7:0] a, input logic [7:0] e);
    xs(op, a, 3'h0, 8'h00);
    chk8(r.rdata, e);
  endtask
  // refused access: flagged and no data
  task automatic rf(input iorsd_op_t op, input logic [7:0] a);
    xs(op, a, 3'h0, 8'h00);
    chk1(r.refused, 1'b1);
    chk8(r.rdata, 8'h00);
  endtask
  task automatic tb(input logic [7:0] a, input logic [2:0] b, input logic e);
    xs(IORSD_OP_TEST_BIT, a, b, 8'h00);
    chk1(r.bit_value, e);
  endtask
  task automatic close_out;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #50000;
    num_errors++;
    close_out();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    pin_b = 8'h00;
    pin_e = 8'h00;
    flag_set = '0;
    repeat (16) @(posedge core_clk);
    #1 reset = 1'b0;
    rd(IORSD_OP_PORT_READ, 8'h1e, IORSD_RESET_VALUE);
    xs(IORSD_OP_PORT_WRITE, 8'h1e, 3'h0, 8'ha5);
    rd(IORSD_OP_MEM_READ, 8'h3e, 8'ha5);
    xs(IORSD_OP_MEM_WRITE, 8'h47, 3'h0, 8'h5c);
    rd(IORSD_OP_PORT_READ, 8'h27, 8'h5c);
    chk8(dut_u.t8_cmp_a, 8'h5c);
    rf(IORSD_OP_PORT_READ, 8'h40);
    xs(IORSD_OP_PORT_WRITE, 8'h05, 3'h0, 8'h00);
    xs(IORSD_OP_SET_BIT, 8'h05, 3'h3, 8'h00);
    xs(IORSD_OP_SET_BIT, 8'h05, 3'h7, 8'h00);
    xs(IORSD_OP_CLEAR_BIT, 8'h05, 3'h3, 8'h00);
    rd(IORSD_OP_PORT_READ, 8'h05, 8'h80);
    tb(8'h05, 3'h7, 1'b1);
    chk8(dut_u.out_b, 8'h80);
    // nvm address pairs a full low byte with a four-bit high byte
    xs(IORSD_OP_PORT_WRITE, 8'h21, 3'h0, 8'h34);
    xs(IORSD_OP_MEM_WRITE, 8'h42, 3'h0, 8'h0a);
    rd(IORSD_OP_PORT_READ, 8'h22, 8'h0a);
    chk8(dut_u.nvm_addr[15:8], 8'h0a);
    chk8(dut_u.nvm_addr[7:0], 8'h34);
    // pulse every flag bit for one cycle; reserved positions must not stick
    @(posedge core_clk);
    #1 flag_set = '1;
    @(posedge core_clk);
    #1 flag_set = '0;
    rd(IORSD_OP_PORT_READ, 8'h15, 8'h07);
    rd(IORSD_OP_PORT_READ, 8'h16, 8'h27);
    chk8(dut_u.flags.t16, 8'h27);
    xs(IORSD_OP_PORT_WRITE, 8'h15, 3'h0, 8'h02);
    rd(IORSD_OP_PORT_READ, 8'h15, 8'h05);
    xs(IORSD_OP_SET_BIT, 8'h15, 3'h0, 8'h00);
    rd(IORSD_OP_PORT_READ, 8'h15, 8'h04);
    xs(IORSD_OP_CLEAR_BIT, 8'h15, 3'h2, 8'h00);
    rd(IORSD_OP_PORT_READ, 8'h15, 8'h04);
    tb(8'h15, 3'h2, 1'b1);
    tb(8'h15, 3'h0, 1'b0);
    tb(8'h1c, 3'h0, 1'b1);
    // a set pulse in the clearing cycle keeps its flag
    fork
      xs(IORSD_OP_PORT_WRITE, 8'h1c, 3'h0, 8'h0f);
      begin
        @(posedge core_clk);
        #1 flag_set.xirq = 8'h01;
        @(posedge core_clk);
        #1 flag_set = '0;
      end
    join
    rd(IORSD_OP_PORT_READ, 8'h1c, 8'h01);
    rf(IORSD_OP_TEST_BIT, 8'h20);
    rf(IORSD_OP_SET_BIT, 8'h60);
    rf(IORSD_OP_PORT_READ, 8'h60);
    rf(IORSD_OP_MEM_READ, 8'h10);
    xs(IORSD_OP_MEM_WRITE, 8'h80, 3'h0, 8'h3c);
    rd(IORSD_OP_MEM_READ, 8'h80, 8'h3c);
    rd(IORSD_OP_PORT_READ, 8'h00, 8'h00);
    rd(IORSD_OP_PORT_READ, 8'h29, 8'h00);
    xs(IORSD_OP_PORT_WRITE, 8'h0e, 3'h0, 8'h07);
    rd(IORSD_OP_MEM_READ, 8'h2e, 8'h07);
    chk8(dut_u.out_e, 8'h07);
    pin_b = 8'h5a;
    pin_e = 8'hff;
    repeat (3) @(posedge core_clk);
    rd(IORSD_OP_PORT_READ, 8'h03, 8'h5a);
    rd(IORSD_OP_PORT_READ, 8'h0c, 8'h07);
    // reset again mid-run: the io registers and their copies return to zero; the extended array keeps its contents
    @(posedge core_clk);
    #1 reset = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 reset = 1'b0;
    chk8(dut_u.out_b, IORSD_RESET_VALUE);
    rd(IORSD_OP_PORT_READ, 8'h05, IORSD_RESET_VALUE);
    rd(IORSD_OP_PORT_READ, 8'h15, IORSD_RESET_VALUE);
    close_out();
  end
endmodule
